// ==== tmu_map.vh ====
// Register map, field positions and reset values of the timer unit.
// Assumes a 32-bit APB slave decoded on paddr[7:2], one word per register.
`ifndef TMU_MAP_VH
`define TMU_MAP_VH

// Word indices on paddr[7:2]
`define TMU_IDX_CTRL0 6'h00
`define TMU_IDX_CNT0 6'h05
`define TMU_IDX_CRVAL 6'h0a
`define TMU_IDX_CRCTL 6'h0b
`define TMU_IDX_STATUS 6'h0c
`define TMU_IDX_IRQ_EN 6'h0d
`define TMU_IDX_IRQ_CLR 6'h0e
`define TMU_IDX_LATCH 6'h0f

// Timer control fields
`define TMU_F_PS 2:0
`define TMU_F_MODE 4:3
`define TMU_B_DOWN 5
`define TMU_B_EXTDIR 6
`define TMU_B_RUN 7
`define TMU_B_GATEPOL 8
`define TMU_B_CHAIN 9
`define TMU_B_WRAPLOAD 10
`define TMU_F_AUXFN 11:10
`define TMU_F_TRIG 13:12
`define TMU_F_EDGE 15:14

// Modes, aux functions, reload triggers
`define TMU_MODE_TIMER 2'h0
`define TMU_MODE_GATED 2'h1
`define TMU_MODE_COUNT 2'h2
`define TMU_MODE_ENC 2'h3
`define TMU_AUX_CAPT 2'h1
`define TMU_AUX_RELD 2'h2
`define TMU_TRIG_RISE 2'h1
`define TMU_TRIG_FALL 2'h2
`define TMU_TRIG_PIN 2'h3

// Capture control fields
`define TMU_F_CREDGE 1:0
`define TMU_B_CRCLR 2

// Prescaler base shifts: 3 and 2, for base factors of 8 and 4
`define TMU_PS_BASE1 3
`define TMU_PS_BASE2 2

// Reset values
`define TMU_CTRL_RST 16'h0000
`define TMU_CNT_RST 16'h0000
`define TMU_CR_RST 16'h0000
`define TMU_STAT_RST 6'h00

`endif

// ==== tmu_timer16.v ====
// One 16-bit up/down timer with prescaler, gate, edge and encoder input.
// Assumes its pin inputs are already synchronised to pclk.
`timescale 1ns/10ps
`include "tmu_map.vh"

module tmu_timer16 #(
   parameter PS_BASE = `TMU_PS_BASE1
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Configuration
   input wire [15:0] ctrl,
   // Synchronised pins
   input wire pin_clk,
   input wire pin_dir,
   // Chain event, stop and load
   input wire chain_tick,
   input wire stop,
   input wire load,
   input wire [15:0] load_val,
   // Results
   output wire [15:0] count,
   output wire wrap
);

   reg [9:0] ps_r;
   reg [15:0] cnt_r;
   reg clk_prev_r;
   reg dir_prev_r;
   wire [10:0] fac;
   wire [9:0] ps_last;
   wire tick;
   wire run;
   wire gate;
   wire enc_step;
   wire enc_down;
   wire down;
   reg step;

   // Edge select: 01 rising, 10 falling, 11 both
   function edge_hit;
      input p;
      input c;
      input [1:0] sel;
      begin
         edge_hit = (sel[0] & ~p & c) | (sel[1] & p & ~c);
      end
   endfunction

   // Prescaler factor doubles per code step
   assign fac = 11'h001 << (PS_BASE + ctrl[`TMU_F_PS]);
   assign ps_last = fac[9:0] - 10'h001;
   assign tick = (ps_r == ps_last);
   assign run = ctrl[`TMU_B_RUN] & ~stop;
   assign gate = (pin_clk == ctrl[`TMU_B_GATEPOL]);
   assign enc_step = (pin_clk ^ clk_prev_r) | (pin_dir ^ dir_prev_r);
   assign enc_down = ~(clk_prev_r ^ pin_dir);
   assign down = (ctrl[`TMU_F_MODE] == `TMU_MODE_ENC) ? enc_down :
      ctrl[`TMU_B_DOWN] ^ (ctrl[`TMU_B_EXTDIR] & pin_dir);
   assign wrap = step & (down ? (cnt_r == 16'h0000) :
      (cnt_r == 16'hffff));
   assign count = cnt_r;

   // Count step per operating mode
   always @* begin
      case (ctrl[`TMU_F_MODE])
         `TMU_MODE_TIMER: step = run & tick;
         `TMU_MODE_GATED: step = run & tick & gate;
         `TMU_MODE_COUNT: step = run & (ctrl[`TMU_B_CHAIN] ? chain_tick :
            edge_hit(clk_prev_r, pin_clk, ctrl[`TMU_F_EDGE]));
         `TMU_MODE_ENC: step = run & enc_step;
         default: step = 1'b0;
      endcase
   end

   // Prescaler, pin history and counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_r <= 10'h000;
         cnt_r <= `TMU_CNT_RST;
         clk_prev_r <= 1'b0;
         dir_prev_r <= 1'b0;
      end else begin
         clk_prev_r <= pin_clk;
         dir_prev_r <= pin_dir;
         if (!run || tick)
            ps_r <= 10'h000;
         else
            ps_r <= ps_r + 10'h001;
         if (load)
            cnt_r <= load_val;
         else if (step && down)
            cnt_r <= cnt_r - 16'h0001;
         else if (step)
            cnt_r <= cnt_r + 16'h0001;
      end
   end

endmodule

// ==== tmu_top.v ====
// Timer unit top: APB slave, five timers, capture register, interrupt.
// Assumes asynchronous pins that are synchronised here before use.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "tmu_map.vh"

module tmu_top (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Timer pins: aux_a, core, aux_b, second module first, second
   input wire [4:0] timer_clock_gate_input,
   input wire [4:0] timer_direction_input,
   input wire capture_input_pin,
   // Outputs
   output reg toggle_latch_output_pin,
   output reg second_module_toggle_output_pin,
   output reg irq
);

   // Timer index numbers
   localparam AUXA = 0;
   localparam CORE = 1;
   localparam AUXB = 2;
   localparam SMF = 3;
   localparam SMS = 4;

   // Register storage
   reg [15:0] ctrl_r [0:4];
   reg [15:0] capture_reload_register_r;
   reg [2:0] crctl_r;
   reg [5:0] status_r;
   reg [5:0] status_nxt;
   reg [5:0] irq_en_r;
   reg core_toggle_latch_r;
   reg second_module_toggle_latch_r;

   // Pin synchronisers and history
   reg [4:0] clk_s1_r;
   reg [4:0] clk_s2_r;
   reg [4:0] dir_s1_r;
   reg [4:0] dir_s2_r;
   reg [4:0] clk_prev_r;
   reg cap_s1_r;
   reg cap_s2_r;
   reg cap_prev_r;

   // Timer interconnect
   wire [79:0] cnt_flat;
   wire [4:0] wrap;
   wire [4:0] chain;
   wire [4:0] stop;
   reg [4:0] ld;
   reg [79:0] ld_flat;

   // Bus decode
   wire [5:0] idx;
   wire acc;
   wire wr_en;
   wire mapped;
   reg [31:0] rd_nxt;
   reg rd_err;

   // Event decode
   wire lat_rise;
   wire lat_fall;
   wire [1:0] fn_a;
   wire [1:0] fn_b;
   wire hit_a;
   wire hit_b;
   wire cap_a;
   wire cap_b;
   wire rel_a;
   wire rel_b;
   wire cr_ev;
   wire [15:0] cnt_a;
   wire [15:0] cnt_c;
   wire [15:0] cnt_b;
   wire [15:0] cnt_sf;
   wire [15:0] cnt_ss;

   integer k;
   integer j;

   // Edge select: 01 rising, 10 falling, 11 both
   function edge_hit;
      input p;
      input c;
      input [1:0] sel;
      begin
         edge_hit = (sel[0] & ~p & c) | (sel[1] & p & ~c);
      end
   endfunction

   // Reload trigger from latch transition or pin edge
   function rel_fire;
      input [1:0] trg;
      input rise;
      input fall;
      input pin_edge;
      begin
         rel_fire = ((trg == `TMU_TRIG_RISE) & rise) |
            ((trg == `TMU_TRIG_FALL) & fall) |
            ((trg == `TMU_TRIG_PIN) & pin_edge);
      end
   endfunction

   // Counter slices
   assign cnt_a = cnt_flat[15:0];
   assign cnt_c = cnt_flat[31:16];
   assign cnt_b = cnt_flat[47:32];
   assign cnt_sf = cnt_flat[63:48];
   assign cnt_ss = cnt_flat[79:64];

   // APB access phase with one wait state
   assign idx = paddr[7:2];
   assign acc = psel & penable;
   assign wr_en = acc & pwrite & pready;
   assign mapped = (idx <= `TMU_IDX_LATCH);

   // Two-flop synchronisers on every pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1_r <= 5'h00;
         clk_s2_r <= 5'h00;
         dir_s1_r <= 5'h00;
         dir_s2_r <= 5'h00;
         clk_prev_r <= 5'h00;
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_prev_r <= 1'b0;
      end else begin
         clk_s1_r <= timer_clock_gate_input;
         clk_s2_r <= clk_s1_r;
         dir_s1_r <= timer_direction_input;
         dir_s2_r <= dir_s1_r;
         clk_prev_r <= clk_s2_r;
         cap_s1_r <= capture_input_pin;
         cap_s2_r <= cap_s1_r;
         cap_prev_r <= cap_s2_r;
      end
   end

   // Core latch transitions, taken from the wrap about to flip it
   assign lat_rise = wrap[CORE] & ~core_toggle_latch_r;
   assign lat_fall = wrap[CORE] & core_toggle_latch_r;

   // Aux timer functions toward the core timer
   assign fn_a = ctrl_r[AUXA][`TMU_F_AUXFN];
   assign fn_b = ctrl_r[AUXB][`TMU_F_AUXFN];
   assign hit_a = edge_hit(clk_prev_r[AUXA], clk_s2_r[AUXA],
      ctrl_r[AUXA][`TMU_F_EDGE]);
   assign hit_b = edge_hit(clk_prev_r[AUXB], clk_s2_r[AUXB],
      ctrl_r[AUXB][`TMU_F_EDGE]);
   assign cap_a = (fn_a == `TMU_AUX_CAPT) & hit_a;
   assign cap_b = (fn_b == `TMU_AUX_CAPT) & hit_b;
   assign rel_a = (fn_a == `TMU_AUX_RELD) & rel_fire(
      ctrl_r[AUXA][`TMU_F_TRIG], lat_rise, lat_fall, hit_a);
   assign rel_b = (fn_b == `TMU_AUX_RELD) & rel_fire(
      ctrl_r[AUXB][`TMU_F_TRIG], lat_rise, lat_fall, hit_b);

   // Capture register event on the capture pin
   assign cr_ev = edge_hit(cap_prev_r, cap_s2_r,
      crctl_r[`TMU_F_CREDGE]);

   // Chain sources and stop while acting as capture or reload
   assign chain[AUXA] = wrap[CORE];
   assign chain[CORE] = wrap[AUXA];
   assign chain[AUXB] = wrap[CORE];
   assign chain[SMF] = wrap[SMS];
   assign chain[SMS] = wrap[SMF];
   assign stop[AUXA] = (fn_a != 2'h0);
   assign stop[CORE] = 1'b0;
   assign stop[AUXB] = (fn_b != 2'h0);
   assign stop[SMF] = 1'b0;
   assign stop[SMS] = 1'b0;

   // Load requests; a software write to a count wins
   always @* begin
      for (k = 0; k < 5; k = k + 1) begin
         ld[k] = wr_en & (idx == `TMU_IDX_CNT0 + k[5:0]);
         ld_flat[16*k +: 16] = pwdata[15:0];
      end
      if (!ld[AUXA] && cap_a) begin
         ld[AUXA] = 1'b1;
         ld_flat[15:0] = cnt_c;
      end
      if (!ld[AUXB] && cap_b) begin
         ld[AUXB] = 1'b1;
         ld_flat[47:32] = cnt_c;
      end
      if (!ld[CORE] && (rel_a || rel_b)) begin
         ld[CORE] = 1'b1;
         ld_flat[31:16] = rel_a ? cnt_a : cnt_b;
      end
      if (!ld[SMF] && cr_ev && crctl_r[`TMU_B_CRCLR]) begin
         ld[SMF] = 1'b1;
         ld_flat[63:48] = 16'h0000;
      end
      if (!ld[SMS] && wrap[SMS] && ctrl_r[SMS][`TMU_B_WRAPLOAD]) begin
         ld[SMS] = 1'b1;
         ld_flat[79:64] = capture_reload_register_r;
      end
   end

   // Five timers, prescale base by module
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : tmr
         tmu_timer16 #(
            .PS_BASE((g < 3) ? `TMU_PS_BASE1 : `TMU_PS_BASE2)
         ) u_tmr (
            .pclk(pclk),
            .presetn(presetn),
            .ctrl(ctrl_r[g]),
            .pin_clk(clk_s2_r[g]),
            .pin_dir(dir_s2_r[g]),
            .chain_tick(chain[g]),
            .stop(stop[g]),
            .load(ld[g]),
            .load_val(ld_flat[16*g +: 16]),
            .count(cnt_flat[16*g +: 16]),
            .wrap(wrap[g])
         );
      end
   endgenerate

   // Read mux
   always @* begin
      rd_nxt = 32'h0000_0000;
      rd_err = 1'b0;
      if (idx < `TMU_IDX_CNT0)
         rd_nxt[15:0] = ctrl_r[idx[2:0]];
      else if (idx < `TMU_IDX_CRVAL)
         rd_nxt[15:0] = cnt_flat[16*(idx - `TMU_IDX_CNT0) +: 16];
      else begin
         case (idx)
            `TMU_IDX_CRVAL: rd_nxt[15:0] = capture_reload_register_r;
            `TMU_IDX_CRCTL: rd_nxt[2:0] = crctl_r;
            `TMU_IDX_STATUS: rd_nxt[5:0] = status_r;
            `TMU_IDX_IRQ_EN: rd_nxt[5:0] = irq_en_r;
            `TMU_IDX_IRQ_CLR: rd_nxt = 32'h0000_0000;
            `TMU_IDX_LATCH: begin
               rd_nxt[0] = core_toggle_latch_r;
               rd_nxt[1] = second_module_toggle_latch_r;
            end
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Sticky events: set wins over a same-cycle clear
   always @* begin
      status_nxt = status_r;
      if (wr_en && idx == `TMU_IDX_IRQ_CLR)
         status_nxt = status_r & ~pwdata[5:0];
      status_nxt = status_nxt | {cr_ev, wrap};
   end

   // APB handshake and read data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & (rd_err | ~mapped);
         if (acc && !pready && !pwrite)
            prdata <= rd_nxt;
      end
   end

   // Software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (j = 0; j < 5; j = j + 1)
            ctrl_r[j] <= `TMU_CTRL_RST;
         crctl_r <= 3'h0;
         irq_en_r <= 6'h00;
      end else if (wr_en) begin
         if (idx < `TMU_IDX_CNT0)
            ctrl_r[idx[2:0]] <= pwdata[15:0];
         if (idx == `TMU_IDX_CRCTL)
            crctl_r <= pwdata[2:0];
         if (idx == `TMU_IDX_IRQ_EN)
            irq_en_r <= pwdata[5:0];
      end
   end

   // Capture register: capture beats a software write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         capture_reload_register_r <= `TMU_CR_RST;
      else if (cr_ev)
         capture_reload_register_r <= cnt_sf;
      else if (wr_en && idx == `TMU_IDX_CRVAL)
         capture_reload_register_r <= pwdata[15:0];
   end

   // Toggle latches, status and interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_toggle_latch_r <= 1'b0;
         second_module_toggle_latch_r <= 1'b0;
         toggle_latch_output_pin <= 1'b0;
         second_module_toggle_output_pin <= 1'b0;
         status_r <= `TMU_STAT_RST;
         irq <= 1'b0;
      end else begin
         if (wrap[CORE])
            core_toggle_latch_r <= ~core_toggle_latch_r;
         if (wrap[SMS])
            second_module_toggle_latch_r <=
               ~second_module_toggle_latch_r;
         toggle_latch_output_pin <= core_toggle_latch_r ^ wrap[CORE];
         second_module_toggle_output_pin <=
            second_module_toggle_latch_r ^ wrap[SMS];
         status_r <= status_nxt;
         irq <= |(status_nxt & irq_en_r);
      end
   end

endmodule

// ==== tmu_top_chk.sv ====
// Checker of bus timing and interrupt behaviour at the timer unit ports.
// Assumes it is bound to tmu_top and sees only that module's ports.
`timescale 1ns/10ps
module tmu_top_chk (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Outputs
   input wire toggle_latch_output_pin,
   input wire second_module_toggle_output_pin,
   input wire irq
);
   wire wr_done;
   // A write completes at this edge
   assign wr_done = psel && penable && pready && pwrite;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_high: assert property (pready && paddr[7:6] != 2'h0 |-> pslverr)
      else $error("no error on unmapped address");
   chk_err_low: assert property (pready && paddr[7:6] == 2'h0 |-> !pslverr)
      else $error("error on mapped address");
   chk_err_data: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (pready && !pwrite
      |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_rdata_hold: assert property (pready && !pwrite
      |=> $stable(prdata)[*2])
      else $error("read data moved");
   chk_irq_sticky: assert property ($fell(irq)
      |-> $past(wr_done) || $past(wr_done, 2))
      else $error("irq fell without a write");
   // Main scenarios
   cov_irq: cover property ($rose(irq));
   cov_core_latch: cover property ($rose(toggle_latch_output_pin));
   cov_second_latch: cover property ($rose(second_module_toggle_output_pin));
endmodule
bind tmu_top tmu_top_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .toggle_latch_output_pin(toggle_latch_output_pin),
   .second_module_toggle_output_pin(second_module_toggle_output_pin),
   .irq(irq)
);

// ==== tmu_pin_model.sv ====
// Model of the external event, gate, encoder and capture sources.
// Assumes the timer unit synchronises every pin to pclk.
`timescale 1ns/10ps
module tmu_pin_model (
   // Clock
   input wire pclk,
   // Pins towards the timer unit
   output reg [4:0] tin,
   output reg [4:0] tdir,
   output reg cap
);
   // Quiet pins from time zero
   initial begin
      tin = 5'h00;
      tdir = 5'h00;
      cap = 1'b0;
   end
   // Keep a level long enough for the synchroniser
   task hold;
      repeat (4)
         @(posedge pclk);
   endtask
   // One high pulse on a clock pin, or on capture when i is 5
   task pulse(input int i);
      @(posedge pclk);
      if (i == 5)
         cap <= 1'b1;
      else
         tin[i] <= 1'b1;
      hold;
      if (i == 5)
         cap <= 1'b0;
      else
         tin[i] <= 1'b0;
      hold;
   endtask
   // Static gate and direction levels
   task set(input int i, input logic a, input logic b);
      @(posedge pclk);
      tin[i] <= a;
      tdir[i] <= b;
      hold;
   endtask
   // Four steps: forward is 00,01,11,10 on A,B
   task quad(input int i, input logic fwd);
      for (int k = 0; k < 4; k++) begin
         @(posedge pclk);
         if (fwd == (k % 2 == 0))
            tdir[i] <= ~tdir[i];
         else
            tin[i] <= ~tin[i];
         hold;
      end
   endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench of the timer unit through APB and its pins.
// Assumes tmu_top, tmu_pin_model and the bound checker.
`timescale 1ns/10ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic tlo, tso, irq;
   wire [4:0] tin, tdir;
   wire cap;
   int err_count, checks, cyc, n;
   // Clock and cycle count
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   tmu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_clock_gate_input(tin), .timer_direction_input(tdir),
      .capture_input_pin(cap), .toggle_latch_output_pin(tlo),
      .second_module_toggle_output_pin(tso), .irq(irq));
   tmu_pin_model pins (.pclk(pclk), .tin(tin), .tdir(tdir), .cap(cap));
   task stop_test;
      $display("Checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string m, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", m, e, g);
      end
   endtask
   task tmo(input int lim);
      if (n >= lim) begin
         err_count++;
         $display("Error wait timed out");
         stop_test;
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tmo(20);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(m, e, rdv);
   endtask
   task ckirq(input logic e);
      repeat (2)
         @(posedge pclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   function logic [7:0] ct(input int t);
      return 8'(t * 4);
   endfunction
   function logic [7:0] ca(input int t);
      return 8'(20 + t * 4);
   endfunction
   // Advance of timer t over a span aligned to 1024 cycles
   task meas(input int t, input int pf);
      int s0;
      int s1;
      logic [15:0] a;
      logic [15:0] d;
      while (cyc % 1024 != 0)
         @(posedge pclk);
      s0 = cyc;
      apb(1'b0, ca(t), 32'h0);
      a = rdv[15:0];
      repeat (1000)
         @(posedge pclk);
      while (cyc % 1024 != 0)
         @(posedge pclk);
      s1 = cyc;
      apb(1'b0, ca(t), 32'h0);
      d = rdv[15:0] - a;
      chk("advance", (pf == 0) ? 0 : (s1 - s0) / pf, {16'h0, d});
   endtask
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {cyc, err_count, checks} = 0;
      repeat (4)
         @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i++)
         if (i != 14)
            rd(8'(i * 4), 32'h0, "reset value");
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, errv});
      for (int c = 0; c < 8; c++) begin
         wr(ct(1), 32'h80 + c);
         wr(ct(3), 32'h80 + c);
         meas(1, 8 << c);
         meas(3, 4 << c);
      end
      wr(ct(1), 32'h0);
      wr(ct(3), 32'h0);
      // Underflow, interrupt mask and clear, then overflow
      wr(8'h34, 32'h2);
      wr(ca(1), 32'h0);
      wr(ct(1), 32'ha0);
      for (n = 0; n < 100 && irq !== 1'b1; n++)
         @(posedge pclk);
      tmo(100);
      chk("latch pin", 32'h1, {31'h0, tlo});
      wr(ct(1), 32'h0);
      apb(1'b0, ca(1), 32'h0);
      chk("underflow", 32'hfff, rdv[15:4]);
      rd(8'h30, 32'h2, "status");
      rd(8'h3c, 32'h1, "latch");
      wr(8'h34, 32'h0);
      ckirq(1'b0);
      wr(8'h34, 32'h2);
      ckirq(1'b1);
      wr(8'h38, 32'h2);
      ckirq(1'b0);
      wr(ca(1), 32'hffff);
      wr(ct(1), 32'h80);
      for (n = 0; n < 100 && tlo !== 1'b0; n++)
         @(posedge pclk);
      tmo(100);
      wr(ct(1), 32'h0);
      wr(8'h38, 32'h2);
      apb(1'b0, ca(1), 32'h0);
      chk("overflow", 32'h0, rdv[15:4]);
      // Pin events, direction pin, gate, encoder
      wr(ct(0), 32'h4090);
      repeat (3)
         pins.pulse(0);
      rd(ca(0), 32'h3, "events");
      pins.set(0, 1'b0, 1'b1);
      wr(ct(0), 32'h40d0);
      repeat (2)
         pins.pulse(0);
      rd(ca(0), 32'h1, "direction pin");
      wr(ct(2), 32'h188);
      meas(2, 0);
      pins.set(2, 1'b1, 1'b0);
      meas(2, 8);
      pins.set(2, 1'b0, 1'b0);
      wr(ca(2), 32'h0);
      wr(ct(2), 32'h98);
      pins.quad(2, 1'b1);
      pins.quad(2, 1'b1);
      rd(ca(2), 32'h8, "encoder");
      pins.quad(2, 1'b0);
      rd(ca(2), 32'h4, "encoder");
      // Capture into aux_timer_a, reload core from aux_timer_b
      wr(ca(1), 32'h1234);
      wr(ct(0), 32'h4480);
      pins.pulse(0);
      rd(ca(0), 32'h1234, "capture");
      wr(ca(2), 32'habc);
      wr(ct(2), 32'h7800);
      pins.pulse(2);
      rd(ca(1), 32'habc, "reload");
      // Capture register with clear, then reload on second timer wrap
      wr(ca(3), 32'h55);
      wr(8'h2c, 32'h5);
      pins.pulse(5);
      rd(8'h28, 32'h55, "capture reg");
      rd(ca(3), 32'h0, "cleared");
      rd(8'h30, 32'h20, "capture flag");
      wr(8'h28, 32'h100);
      wr(ca(4), 32'hffff);
      wr(ct(4), 32'h480);
      for (n = 0; n < 50 && tso !== 1'b1; n++)
         @(posedge pclk);
      tmo(50);
      wr(ct(4), 32'h0);
      apb(1'b0, ca(4), 32'h0);
      chk("wrap reload", 32'h1, rdv[15:8]);
      rd(8'h3c, 32'h2, "latch");
      // Chain: second timer counts first timer wraps
      wr(ca(4), 32'h0);
      wr(ct(4), 32'h290);
      wr(ca(3), 32'hfffe);
      wr(ct(3), 32'h80);
      repeat (20)
         @(posedge pclk);
      wr(ct(3), 32'h0);
      rd(ca(4), 32'h1, "chain");
      // Alternating reload of the core timer on latch edges
      wr(ct(0), 32'h1800);
      wr(ct(2), 32'h2800);
      wr(ca(0), 32'hfffc);
      wr(ca(2), 32'hfff8);
      wr(ca(1), 32'hfffe);
      wr(ct(1), 32'h80);
      for (n = 0; n < 100 && tlo !== 1'b1; n++)
         @(posedge pclk);
      tmo(100);
      for (n = 0; n < 200 && tlo === 1'b1; n++)
         @(posedge pclk);
      chk("high time", 32'h20, n);
      for (n = 0; n < 200 && tlo === 1'b0; n++)
         @(posedge pclk);
      chk("low time", 32'h40, n);
      wr(ct(1), 32'h0);
      stop_test;
   end
endmodule
